/* tws_pkg.sv */
package tws_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Link sampling clock and spike rejection
  ////////////////////////////////////////////////////////////////////////

  // Period of the link sampling clock
  localparam int LINK_PERIOD_NS = 48;
  // Widest spike rejected at standard and fast rates
  localparam int SPIKE_FAST_NS = 50;
  // Widest spike rejected at the high-speed rate
  localparam int SPIKE_HS_NS = 10;
  // Samples a new level must hold; a spike may straddle one extra sample
  localparam logic [1:0] SPIKE_FAST_CYC = 2'(SPIKE_FAST_NS / LINK_PERIOD_NS + 2);
  localparam logic [1:0] SPIKE_HS_CYC = 2'(SPIKE_HS_NS / LINK_PERIOD_NS + 2);
  // Straps need no spike filter beyond the synchroniser agreement
  localparam logic [1:0] STRAP_FILT_CYC = 2'h1;
  // Link cycles after reset release before the straps are latched
  localparam logic [2:0] STRAP_SETTLE = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // Framing and address layout
  ////////////////////////////////////////////////////////////////////////

  // Fixed upper five address bits
  localparam logic [4:0] ADDR_FIXED = 5'h13;
  // Upper five bits of the high-speed master code
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  // Data bits per byte group
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Direction bit value that makes the device transmit
  localparam logic DIR_MASTER_RX = 1'b0;
  // Position of the channel select field in the control byte
  localparam int CHAN_SEL_LSB = 1;
  // Converter code width and reset value
  localparam int CODE_W = 10;
  localparam logic [9:0] CODE_RST = 10'h000;
  // Filler below the two code bits of the low byte
  localparam logic [5:0] LSB_PAD = 6'h00;

  ////////////////////////////////////////////////////////////////////////
  // State encodings
  ////////////////////////////////////////////////////////////////////////

  // Bus engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_RACK = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_SKIP = 6'h20
  } tws_state_t;

  // Meaning of the next byte
  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_CTRL = 4'h2,
    PH_MSB  = 4'h4,
    PH_LSB  = 4'h8
  } tws_phase_t;

endpackage

/* tws_glitch_filter.sv */
`timescale 1ns/1ps
module tws_glitch_filter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Raw pin and required hold length
  input wire logic i_pin,
  input wire logic [1:0] i_hold_len,
  // Filtered level
  output logic o_level
);

  ////////////////////////////////////////////////////////////////////////
  // Three stage synchroniser
  ////////////////////////////////////////////////////////////////////////

  logic s1_reg; // First stage, read only by the second
  logic s2_reg; // Second stage
  logic s3_reg; // Third stage
  logic [1:0] run_reg; // Samples the new level has held
  logic level_reg; // Accepted level, idles high

  // Pin sampling chain
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= i_pin; // RULE_17
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Spike rejection
  ////////////////////////////////////////////////////////////////////////

  logic agree; // Second and third stages match
  logic [2:0] run_next; // Run length including this sample
  assign agree = (s2_reg == s3_reg);
  assign run_next = {1'b0, run_reg} + 3'h1;

  // Count how long a differing level has held
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_reg <= 2'h0;
    end else if (!agree || (s3_reg == level_reg)) begin
      run_reg <= 2'h0;
    end else begin
      run_reg <= run_next[1:0];
    end
  end

  // Accept the level only once it outlasts the spike width
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      level_reg <= 1'b1;
    end else if (agree && (s3_reg != level_reg) && (run_next >= {1'b0, i_hold_len})) begin
      level_reg <= s3_reg; // RULE_14
    end
  end

  assign o_level = level_reg;

  // A change is only ever taken from agreeing stages
  level_agree_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_14
    (level_reg != $past(level_reg)) |-> $past(agree))
    else $error("filtered level changed without stage agreement");

endmodule

/* tws_event_sync.sv */
`timescale 1ns/1ps
module tws_event_sync (
  // Clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Toggle from the sending domain
  input wire logic i_toggle,
  // One-cycle pulse per toggle
  output logic o_pulse
);

  logic t1_reg; // First stage, read only by the second
  logic t2_reg; // Second stage
  logic t3_reg; // Previous settled value

  // Toggle synchroniser
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t1_reg <= 1'b0;
      t2_reg <= 1'b0;
      t3_reg <= 1'b0;
    end else begin
      t1_reg <= i_toggle;
      t2_reg <= t1_reg;
      t3_reg <= t2_reg;
    end
  end

  // Either edge of the settled toggle is one event
  assign o_pulse = t2_reg ^ t3_reg;

endmodule

/* tws_slave_front.sv */
`timescale 1ns/1ps
//
// Behaviour
// RULE_01 - Slave only, standard, fast, high-speed rates
// RULE_02 - Same framing; high-speed is separate variant
// RULE_03 - Seven-bit addresses only, no general call
// RULE_04 - Start: data falls while clock high
// RULE_05 - Master clocks, sends address and direction
// RULE_06 - Data stable while clock high
// RULE_07 - Acknowledge own address on ninth clock
// RULE_08 - Direction one writes, zero reads device
// RULE_09 - Receiver of each byte acknowledges it
// RULE_10 - Unlimited eight-plus-acknowledge byte groups
// RULE_11 - Stop: data rises while clock high
// RULE_12 - After stop release bus, await address
// RULE_13 - Load unsigned ten-bit code into channel
// RULE_14 - Reject spikes of 50 or 10 ns
// RULE_15 - Master code enables high-speed until stop
// RULE_16 - Address is 10011, straps, direction
// RULE_17 - Synchronise pins; reset idles, bus released
// RULE_18 - Start anywhere restarts address reception
module tws_slave_front (
  // Core clock, link sampling clock and reset
  input wire logic i_clk,
  input wire logic i_link_clk,
  input wire logic i_rst_b,
  // Two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_b,
  // Device select straps
  input wire logic i_device_select_high_pin,
  input wire logic i_device_select_low_pin,
  // Converter register side, core clock
  output logic [9:0] o_code_ch0,
  output logic [9:0] o_code_ch1,
  output logic [9:0] o_code_ch2,
  output logic [9:0] o_code_ch3,
  output logic o_update_pulse,
  output logic [1:0] o_update_chan,
  // Link status, link clock
  output logic o_hs_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Link domain: filtered pins and bus events
  ////////////////////////////////////////////////////////////////////////

  logic scl_f; // Filtered clock line
  logic sda_f; // Filtered data line
  logic scl_q; // Clock line one sample ago
  logic sda_q; // Data line one sample ago
  logic hs_reg; // High-speed variant active
  logic [1:0] spike_len; // Filter length for the current rate
  logic sel_hi_f; // Filtered high select strap
  logic sel_lo_f; // Filtered low select strap

  // Shorter filter in the high-speed variant
  assign spike_len = hs_reg ? tws_pkg::SPIKE_HS_CYC : tws_pkg::SPIKE_FAST_CYC; // RULE_02

  tws_glitch_filter u_scl_filt (
    .i_clk(i_link_clk), .i_rst_b(i_rst_b), .i_pin(i_scl),
    .i_hold_len(spike_len), .o_level(scl_f)
  );
  tws_glitch_filter u_sda_filt (
    .i_clk(i_link_clk), .i_rst_b(i_rst_b), .i_pin(i_sda),
    .i_hold_len(spike_len), .o_level(sda_f)
  );
  tws_glitch_filter u_hi_filt (
    .i_clk(i_link_clk), .i_rst_b(i_rst_b), .i_pin(i_device_select_high_pin),
    .i_hold_len(tws_pkg::STRAP_FILT_CYC), .o_level(sel_hi_f)
  );
  tws_glitch_filter u_lo_filt (
    .i_clk(i_link_clk), .i_rst_b(i_rst_b), .i_pin(i_device_select_low_pin),
    .i_hold_len(tws_pkg::STRAP_FILT_CYC), .o_level(sel_lo_f)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  logic scl_rise; // Clock line rising
  logic scl_fall; // Clock line falling
  logic start_det; // Start or repeated start
  logic stop_det; // Stop
  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign start_det = scl_f & scl_q & sda_q & ~sda_f; // RULE_04
  assign stop_det = scl_f & scl_q & ~sda_q & sda_f; // RULE_11

  ////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  ////////////////////////////////////////////////////////////////////////

  logic [2:0] strap_cnt_reg; // Settling counter
  logic strap_done_reg; // Straps latched
  logic [1:0] strap_reg; // Latched select bits

  // Latch the straps once, when the filters have settled
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_cnt_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      strap_reg <= 2'h0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == tws_pkg::STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        strap_reg <= {sel_hi_f, sel_lo_f}; // RULE_16
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte engine
  ////////////////////////////////////////////////////////////////////////

  tws_pkg::tws_state_t state_reg; // Engine state
  tws_pkg::tws_phase_t phase_reg; // Meaning of the current byte
  logic [3:0] bit_cnt_reg; // Bits moved in the current byte
  logic [7:0] rx_shift_reg; // Received byte
  logic dir_reg; // Direction bit of the last address byte received
  logic byte_end; // Eighth bit received and clock fell
  logic addr_match; // Received address is ours
  logic hs_code_seen; // Received byte is the master code
  logic ack_byte; // Device acknowledges this byte

  assign byte_end = (state_reg == tws_pkg::ST_RX) && scl_fall
                    && (bit_cnt_reg == tws_pkg::BYTE_BITS); // RULE_10
  assign addr_match = strap_done_reg
                      && (rx_shift_reg[7:1] == {tws_pkg::ADDR_FIXED, strap_reg}); // RULE_16
  assign hs_code_seen = (rx_shift_reg[7:3] == tws_pkg::HS_CODE_TOP);
  // Only our 7-bit address; general call and 10-bit prefixes never match
  assign ack_byte = (phase_reg != tws_pkg::PH_ADDR) || addr_match; // RULE_03 RULE_09

  // State, bit count, phase and receive shifter
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= tws_pkg::ST_IDLE; // RULE_17
      phase_reg <= tws_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      dir_reg <= 1'b1;
    end else if (start_det) begin
      // Restart address reception from any state
      state_reg <= tws_pkg::ST_RX; // RULE_18 RULE_05
      phase_reg <= tws_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_det) begin
      state_reg <= tws_pkg::ST_IDLE; // RULE_12
      phase_reg <= tws_pkg::PH_ADDR;
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        tws_pkg::ST_RX: begin
          // Sample on rising clock; data is stable while it is high
          if (scl_rise && (bit_cnt_reg != tws_pkg::BYTE_BITS)) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_f}; // RULE_06
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= ack_byte ? tws_pkg::ST_RACK : tws_pkg::ST_SKIP; // RULE_07
            case (phase_reg)
              tws_pkg::PH_ADDR: begin
                dir_reg <= rx_shift_reg[0]; // RULE_08
                phase_reg <= (rx_shift_reg[0] == tws_pkg::DIR_MASTER_RX)
                             ? tws_pkg::PH_MSB : tws_pkg::PH_CTRL;
              end
              tws_pkg::PH_CTRL: phase_reg <= tws_pkg::PH_MSB;
              tws_pkg::PH_MSB: phase_reg <= tws_pkg::PH_LSB;
              default: phase_reg <= tws_pkg::PH_MSB;
            endcase
          end
        end
        tws_pkg::ST_RACK: begin
          // Ninth clock over: transmit or keep receiving
          if (scl_fall) begin
            if (dir_reg == tws_pkg::DIR_MASTER_RX) begin
              state_reg <= tws_pkg::ST_TX; // RULE_08
              bit_cnt_reg <= 4'h1;
            end else begin
              state_reg <= tws_pkg::ST_RX;
              bit_cnt_reg <= 4'h0;
            end
          end
        end
        tws_pkg::ST_TX: begin
          // One bit leaves per falling clock
          if (scl_fall) begin
            if (bit_cnt_reg == tws_pkg::BYTE_BITS) begin
              state_reg <= tws_pkg::ST_MACK;
              bit_cnt_reg <= 4'h0;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        tws_pkg::ST_MACK: begin
          // Master not acknowledging ends our transmission
          if (scl_rise && sda_f) begin
            state_reg <= tws_pkg::ST_SKIP; // RULE_09
          end else if (scl_fall) begin
            state_reg <= tws_pkg::ST_TX;
            bit_cnt_reg <= 4'h1;
            phase_reg <= (phase_reg == tws_pkg::PH_MSB) ? tws_pkg::PH_LSB : tws_pkg::PH_MSB;
          end
        end
        tws_pkg::ST_IDLE, tws_pkg::ST_SKIP: begin
          // Wait for start or stop
          state_reg <= state_reg;
        end
        default: state_reg <= tws_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel select, code assembly and readback shadow
  ////////////////////////////////////////////////////////////////////////

  logic [1:0] chan_reg; // Channel from the control byte
  logic [7:0] msb_hold_reg; // High byte awaiting its low byte
  logic [9:0] shadow_reg [4]; // Last codes written, for readback
  logic [9:0] hold_code_reg; // Code crossing to the core
  logic [1:0] hold_chan_reg; // Channel crossing to the core
  logic upd_toggle_reg; // Flips once per finished code

  // Channel select and high byte capture
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chan_reg <= 2'h0;
      msb_hold_reg <= 8'h00;
    end else if (byte_end && (phase_reg == tws_pkg::PH_CTRL)) begin
      chan_reg <= rx_shift_reg[tws_pkg::CHAN_SEL_LSB +: 2];
    end else if (byte_end && (phase_reg == tws_pkg::PH_MSB)) begin
      msb_hold_reg <= rx_shift_reg;
    end
  end

  // Finished code is held stable and announced by a toggle
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_code_reg <= tws_pkg::CODE_RST;
      hold_chan_reg <= 2'h0;
      upd_toggle_reg <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        shadow_reg[i] <= tws_pkg::CODE_RST;
      end
    end else if (byte_end && (phase_reg == tws_pkg::PH_LSB)) begin
      hold_code_reg <= {msb_hold_reg, rx_shift_reg[7:6]}; // RULE_13
      hold_chan_reg <= chan_reg;
      upd_toggle_reg <= ~upd_toggle_reg;
      shadow_reg[chan_reg] <= {msb_hold_reg, rx_shift_reg[7:6]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line drive
  ////////////////////////////////////////////////////////////////////////

  logic sda_rel_reg; // High releases the data line
  logic [7:0] tx_shift_reg; // Bits still to send
  logic tx_msb_sel; // Next byte out is the high byte
  logic [7:0] tx_byte; // Next byte out
  assign tx_msb_sel = (state_reg == tws_pkg::ST_RACK) == (phase_reg == tws_pkg::PH_MSB);
  assign tx_byte = tx_msb_sel ? shadow_reg[chan_reg][9:2]
                              : {shadow_reg[chan_reg][1:0], tws_pkg::LSB_PAD};

  // Acknowledge and transmit bits change only while the clock is low
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_rel_reg <= 1'b1; // RULE_17
      tx_shift_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_rel_reg <= 1'b1; // RULE_12
    end else if (byte_end) begin
      sda_rel_reg <= ~ack_byte; // RULE_07 RULE_09
    end else if (scl_fall && ((state_reg == tws_pkg::ST_RACK) || (state_reg == tws_pkg::ST_MACK))) begin
      if ((state_reg == tws_pkg::ST_MACK) || (dir_reg == tws_pkg::DIR_MASTER_RX)) begin
        sda_rel_reg <= tx_byte[7];
        tx_shift_reg <= {tx_byte[6:0], 1'b0};
      end else begin
        sda_rel_reg <= 1'b1;
      end
    end else if (scl_fall && (state_reg == tws_pkg::ST_TX)) begin
      // Release for the master's acknowledge after the eighth bit
      sda_rel_reg <= (bit_cnt_reg == tws_pkg::BYTE_BITS) ? 1'b1 : tx_shift_reg[7];
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe_b = sda_rel_reg;

  // Master code switches to the high-speed variant until stop
  always_ff @(posedge i_link_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hs_reg <= 1'b0;
    end else if (stop_det) begin
      hs_reg <= 1'b0; // RULE_15
    end else if (byte_end && (phase_reg == tws_pkg::PH_ADDR) && hs_code_seen) begin
      hs_reg <= 1'b1; // RULE_15 RULE_01
    end
  end

  assign o_hs_mode = hs_reg;

  ////////////////////////////////////////////////////////////////////////
  // Core domain: converter registers
  ////////////////////////////////////////////////////////////////////////

  logic upd_pulse; // Finished code arrived
  logic [9:0] code_reg [4]; // Converter registers
  logic update_reg; // Update strobe
  logic [1:0] upd_chan_reg; // Channel just updated

  tws_event_sync u_upd_sync (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_toggle(upd_toggle_reg), .o_pulse(upd_pulse)
  );

  // Held code is stable for many link cycles when the pulse arrives
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      update_reg <= 1'b0;
      upd_chan_reg <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        code_reg[i] <= tws_pkg::CODE_RST;
      end
    end else begin
      update_reg <= upd_pulse;
      if (upd_pulse) begin
        code_reg[hold_chan_reg] <= hold_code_reg; // RULE_13
        upd_chan_reg <= hold_chan_reg;
      end
    end
  end

  assign o_code_ch0 = code_reg[0];
  assign o_code_ch1 = code_reg[1];
  assign o_code_ch2 = code_reg[2];
  assign o_code_ch3 = code_reg[3];
  assign o_update_pulse = update_reg;
  assign o_update_chan = upd_chan_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  ////////////////////////////////////////////////////////////////////////

  addr_ack_drive_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_07
    (byte_end && (phase_reg == tws_pkg::PH_ADDR) && addr_match) |=> !o_sda_oe_b
      && (state_reg == tws_pkg::ST_RACK))
    else $error("own address not acknowledged");
  ack_held_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_07
    ((state_reg == tws_pkg::ST_RACK) && !scl_fall && !start_det && !stop_det) |=> !sda_rel_reg)
    else $error("acknowledge released early");
  no_gencall_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_03
    (byte_end && (phase_reg == tws_pkg::PH_ADDR) && (rx_shift_reg == 8'h00)) |=>
      sda_rel_reg && (state_reg == tws_pkg::ST_SKIP))
    else $error("general call answered");
  start_restart_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_18
    start_det |=> (state_reg == tws_pkg::ST_RX) && (bit_cnt_reg == 4'h0)
      && (phase_reg == tws_pkg::PH_ADDR) && sda_rel_reg)
    else $error("start did not restart address reception");
  stop_idle_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_12
    stop_det |=> (state_reg == tws_pkg::ST_IDLE) && sda_rel_reg && !hs_reg)
    else $error("stop did not release bus");
  hs_enter_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_15
    (byte_end && (phase_reg == tws_pkg::PH_ADDR) && hs_code_seen) |=> hs_reg && sda_rel_reg)
    else $error("master code mishandled");
  dir_read_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_08
    ((state_reg == tws_pkg::ST_RACK) && scl_fall && (dir_reg == tws_pkg::DIR_MASTER_RX))
      |=> (state_reg == tws_pkg::ST_TX) && (sda_rel_reg == $past(tx_byte[7])))
    else $error("read direction did not transmit");
  code_toggle_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_b) // RULE_10
    (byte_end && (phase_reg == tws_pkg::PH_LSB)) |=> (upd_toggle_reg != $past(upd_toggle_reg))
      ##1 (phase_reg == tws_pkg::PH_MSB))
    else $error("code group not finished");
  code_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_13
    upd_pulse |=> o_update_pulse && (code_reg[o_update_chan] == hold_code_reg))
    else $error("converter register not loaded");

  addr_ack_c: cover property (@(posedge i_link_clk) disable iff (!i_rst_b)
    byte_end && (phase_reg == tws_pkg::PH_ADDR) && addr_match);
  hs_enter_c: cover property (@(posedge i_link_clk) disable iff (!i_rst_b)
    byte_end && (phase_reg == tws_pkg::PH_ADDR) && hs_code_seen);
  read_nack_c: cover property (@(posedge i_link_clk) disable iff (!i_rst_b)
    (state_reg == tws_pkg::ST_MACK) && scl_rise && sda_f);
  code_load_c: cover property (@(posedge i_clk) disable iff (!i_rst_b) upd_pulse);

endmodule

/* tws_bus_master.sv */
`timescale 1ns/1ps
module tws_bus_master (
  // Pacing clock and resolved data line
  input wire logic i_clk,
  input wire logic i_sda,
  // Bus lines, high means released
  output logic o_scl = 1'b1,
  output logic o_sda = 1'b1
);
  // Set both lines, then hold a quarter bit, five link cycles long
  task automatic st(input logic c, input logic d);
    o_scl = c;
    o_sda = d;
    repeat (6) @(negedge i_clk);
  endtask
  // One clock pulse, data only moves while the clock is low
  task automatic bitx(input logic d, output logic s);
    st(1'b0, d);
    st(1'b1, d);
    s = i_sda;
    st(1'b1, d);
    st(1'b0, d);
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start();
    st(o_scl, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask
  // Stop, data rises while clock high
  task automatic stop();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  // Eight data bits then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] r,
                       output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(ai, ao);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  // Clocks, reset, straps, spike injector
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic g = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] bad[4];
  logic [7:0] r;
  logic a;
  // Wired-and data line with pull-up
  wire logic m_scl, m_sda, oe_b, sd_o, upd, hs;
  wire logic sda = m_sda & (oe_b | sd_o);
  wire logic [9:0] c[4];
  wire logic [1:0] uch;
  // Model of the converter codes and counters
  int ex[4] = '{4{0}};
  int nex = 0;
  int npl = 0;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end
  tws_bus_master m (.i_clk(clk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  tws_slave_front dut (.i_clk(clk), .i_link_clk(lclk), .i_rst_b(rst_b), .i_scl(m_scl | g),
    .i_sda(sda), .o_sda_out(sd_o), .o_sda_oe_b(oe_b), .i_device_select_high_pin(sel[1]),
    .i_device_select_low_pin(sel[0]), .o_code_ch0(c[0]), .o_code_ch1(c[1]),
    .o_code_ch2(c[2]), .o_code_ch3(c[3]), .o_update_pulse(upd), .o_update_chan(uch),
    .o_hs_mode(hs));
  // Count load pulses once they have settled; cut a hang short
  always @(negedge clk) begin
    npl += (upd === 1'b1);
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One byte written by the master, acknowledge checked
  task automatic tx(input logic [7:0] d, input logic e);
    m.xbyte(d, 1'b1, r, a);
    `CHK("ack", e, a)
  endtask
  // Address, control, spike at F/S rate, then a code pair
  task automatic wr(input logic [7:0] ad, input int ch, input int v, input logic e);
    m.start();
    tx(ad, e);
    tx({5'h00, 2'(ch), 1'b0}, e);
    if (hs !== 1'b1) begin
      @(negedge clk) g = 1'b1;
      @(negedge clk) g = 1'b0;
    end
    tx(8'(v >> 2), e);
    tx({2'(v), 6'($urandom)}, e);
    if (e === 1'b0) begin
      ex[ch] = v;
      nex++;
      `CHK("chan", 2'(ch), uch)
    end
  endtask
  // Let the load cross, then compare all codes and pulses
  task automatic chk();
    repeat (12) @(negedge clk);
    for (int i = 0; i < 4; i++) `CHK("code", 10'(ex[i]), c[i])
    `CHK("loads", nex, npl)
  endtask
  initial begin
    void'($urandom(11246));
    sel = 2'($urandom);
    repeat (8) @(negedge clk);
    `CHK("rst_rel", 1'b1, oe_b)
    rst_b = 1'b1;
    repeat (30) @(negedge clk);
    for (int ch = 0; ch < 4; ch++) begin
      wr({5'h13, sel, 1'b1}, ch, ch == 0 ? 1023 : ch == 1 ? 0 : $urandom % 1024, 1'b0);
      m.stop();
      chk();
    end
    $display("write test done");
    bad = '{8'h00, 8'hF1, {5'h13, ~sel, 1'b1}, {5'h12, sel, 1'b1}};
    foreach (bad[i]) begin
      wr(bad[i], 2, 5, 1'b1);
      m.stop();
      chk();
    end
    $display("address test done");
    m.start();
    tx({5'h13, sel, 1'b1}, 1'b0);
    for (int i = 0; i < 4; i++) m.bitx(1'b0, a);
    wr({5'h13, sel, 1'b1}, 3, $urandom % 1024, 1'b0);
    m.stop();
    chk();
    $display("restart test done");
    m.start();
    tx({5'h13, sel, 1'b0}, 1'b0);
    m.xbyte(8'hFF, 1'b0, r, a);
    `CHK("rd_msb", 8'(ex[3] >> 2), r)
    m.xbyte(8'hFF, 1'b1, r, a);
    `CHK("rd_lsb", {2'(ex[3]), 6'h00}, r)
    m.stop();
    $display("read test done");
    m.start();
    tx(8'h0B, 1'b1);
    `CHK("hs_on", 1'b1, hs)
    wr({5'h13, sel, 1'b1}, 2, $urandom % 1024, 1'b0);
    m.stop();
    chk();
    `CHK("hs_off", 1'b0, hs)
    $display("high-speed test done");
    complete_run();
  end
endmodule
